//--- dram_hit_map.svh
// register offsets, field positions and reset values for the dram block hit decoder
// assumes inclusion by every file that decodes or drives these registers
`ifndef DRAM_HIT_MAP_SVH
`define DRAM_HIT_MAP_SVH

// byte offsets on the register bus
`define OFS_BLK0_COMPARE 4'h0
`define OFS_BLK0_MASK 4'h4
`define OFS_BLK1_COMPARE 4'h8
`define OFS_BLK1_MASK 4'hC

// mask register fields
`define FLD_CMP_HI 31
`define FLD_CMP_LO 18
`define FLD_WPROT 8
`define FLD_TYPE_HI 6
`define FLD_TYPE_LO 1
`define FLD_DECODE_ON 0

// writable bits of each register; reserved bits are held at zero
`define MASK_WRITABLE 32'hFFFC017F
`define COMPARE_WRITABLE 32'hFFFC0000

// reset values
`define MASK_RESET 32'h00000000
`define COMPARE_RESET 32'h00000000

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- dram_hit_pkg.sv
// types shared by the dram block hit decoder
// assumes the map header for all numeric constants
`default_nettype none
package dram_hit_pkg;

  // one bus cycle in progress, as presented by the internal master
  typedef struct packed {
    logic [31:0] addr;      // cycle address
    logic write;            // write cycle
    logic cpu_space_iack;   // control-register move or interrupt acknowledge
    logic alternate_master; // external or dma master
    logic privileged_code;  // supervisor instruction access
    logic privileged_data;  // supervisor data access
    logic user_code;        // user instruction access
    logic user_data;        // user data access
  } bus_cycle_t;

  // decode outcome toward the dram timing and chip-select logic
  typedef struct packed {
    logic [1:0] block_hit;  // per-block hit that may run a dram cycle
    logic wprot_reject;     // write refused by a protected block
    logic pass_to_cs;       // cycle handed to chip-select decoder
  } hit_result_t;

  // external fallback cycle tracking
  typedef enum logic [1:0] {
    EXT_IDLE,
    EXT_WAIT
  } ext_state_t;

endpackage : dram_hit_pkg
`default_nettype wire

//--- dram_block_hit_mask_decode.sv
// hit decoder for two dram blocks with axi4-lite access to compare and mask registers
// assumes a single 25 mhz clock; bus cycle inputs come from logic on that clock
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "dram_hit_map.svh"

module dram_block_hit_mask_decode #(
  parameter int EXT_TIMEOUT = 16 // cycles an external fallback cycle waits for acknowledge
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  // axi4-lite slave
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // bus cycle from the internal master
  input wire logic CYCLE_VALID,
  input wire dram_hit_pkg::bus_cycle_t CYCLE,
  // chip-select decoder answer for a handed-over cycle
  input wire logic CS_HIT,
  // acknowledge of the external fallback cycle
  input wire logic EXT_ACK,
  // decode outcome
  output dram_hit_pkg::hit_result_t RESULT,
  output logic EXT_START,
  output logic ADDR_EXCEPTION,
  output logic ACCESS_EXCEPTION
);

  // ==========================================================
  // register file
  // ==========================================================
  logic [31:0] compare_q [2];  // block base compare values
  logic [31:0] mask_q [2];     // block hit mask registers
  logic aw_got_q;              // write address held
  logic w_got_q;               // write data held
  logic [3:0] awaddr_q;        // captured write address
  logic [31:0] wdata_q;        // captured write data
  logic [3:0] wstrb_q;         // captured byte strobes
  logic bvalid_q;              // write response pending
  logic [1:0] bresp_q;         // write response code
  logic rvalid_q;              // read data pending
  logic [31:0] rdata_q;        // read data
  logic [1:0] rresp_q;         // read response code
  logic wr_fire;               // both halves of a write held
  logic [31:0] strb_mask;      // byte enables widened to bits

  // address and data are accepted independently; ready drops once held
  assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
  assign S_AXI_WREADY = !w_got_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // capture of the write address and data channels
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // register update and write response; reserved bits never store, so they read zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      compare_q[0] <= `COMPARE_RESET;
      compare_q[1] <= `COMPARE_RESET;
      mask_q[0] <= `MASK_RESET; // decode enable cleared
      mask_q[1] <= `MASK_RESET; // decode enable cleared
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= `RESP_OKAY;
        case (awaddr_q)
          `OFS_BLK0_COMPARE: begin
            compare_q[0] <= (compare_q[0] & ~strb_mask) | (wdata_q & strb_mask & `COMPARE_WRITABLE);
          end
          `OFS_BLK0_MASK: begin
            // reserved mask bits dropped even if software sets them
            mask_q[0] <= (mask_q[0] & ~strb_mask) | (wdata_q & strb_mask & `MASK_WRITABLE);
          end
          `OFS_BLK1_COMPARE: begin
            compare_q[1] <= (compare_q[1] & ~strb_mask) | (wdata_q & strb_mask & `COMPARE_WRITABLE);
          end
          `OFS_BLK1_MASK: begin
            mask_q[1] <= (mask_q[1] & ~strb_mask) | (wdata_q & strb_mask & `MASK_WRITABLE);
          end
          default: begin
            // unmapped address: nothing stored, error answer
            bresp_q <= `RESP_SLVERR;
          end
        endcase
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel; answer one cycle after the address is taken
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_q <= 1'b1;
        rresp_q <= `RESP_OKAY;
        case (S_AXI_ARADDR)
          `OFS_BLK0_COMPARE: rdata_q <= compare_q[0];
          `OFS_BLK0_MASK: rdata_q <= mask_q[0];
          `OFS_BLK1_COMPARE: rdata_q <= compare_q[1];
          `OFS_BLK1_MASK: rdata_q <= mask_q[1];
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // hit decode
  // ==========================================================
  logic [1:0] raw_hit;     // address, type and enable all match
  logic [1:0] prot_hit;    // raw hit that is a write to a protected block
  logic [5:0] cyc_types;   // access type vector in mask bit order

  // type order follows the mask field, bit six first
  assign cyc_types = {CYCLE.cpu_space_iack, CYCLE.alternate_master, CYCLE.privileged_code,
                      CYCLE.privileged_data, CYCLE.user_code, CYCLE.user_data};

  // one identical decoder per block
  for (genvar b = 0; b < 2; b++) begin : g_blk
    logic addr_match; // all unmasked address bits equal
    logic type_ok;    // no active type of this cycle is masked
    // per-bit masking, so any mask pattern works
    assign addr_match = (((CYCLE.addr[`FLD_CMP_HI:`FLD_CMP_LO]
                         ^ compare_q[b][`FLD_CMP_HI:`FLD_CMP_LO])
                         & ~mask_q[b][`FLD_CMP_HI:`FLD_CMP_LO]) == 14'h0000);
    // a set type mask bit blocks a cycle of that type
    assign type_ok = ((cyc_types & mask_q[b][`FLD_TYPE_HI:`FLD_TYPE_LO]) == 6'h00);
    // nothing decodes while the enable bit is clear
    assign raw_hit[b] = CYCLE_VALID && mask_q[b][`FLD_DECODE_ON] && addr_match && type_ok;
    // writes into a protected block are refused
    assign prot_hit[b] = raw_hit[b] && CYCLE.write && mask_q[b][`FLD_WPROT];
  end

  // ==========================================================
  // outcome registers and external fallback
  // ==========================================================
  // one cycle beyond the last cycle at which a fallback outcome may be seen, counted from the start pulse
  localparam int EXC_LAT = EXT_TIMEOUT + 1;
  dram_hit_pkg::ext_state_t ext_q;  // fallback cycle tracker
  logic [7:0] ext_cnt_q;            // cycles waited for acknowledge
  logic refused;                    // a protected write seen this cycle

  assign refused = |prot_hit;

  // registered decode outcome, one cycle behind the bus cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RESULT <= '0;
      ADDR_EXCEPTION <= 1'b0;
    end else begin
      RESULT.block_hit <= raw_hit & ~prot_hit;    // refused write runs no dram cycle
      RESULT.wprot_reject <= refused;
      RESULT.pass_to_cs <= refused;               // handed to chip-select
      ADDR_EXCEPTION <= refused;                  // one-cycle exception pulse
    end
  end

  // fallback external cycle when chip-select misses; timeout means no acknowledge
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_q <= dram_hit_pkg::EXT_IDLE;
      ext_cnt_q <= 8'h00;
      EXT_START <= 1'b0;
      ACCESS_EXCEPTION <= 1'b0;
    end else begin
      EXT_START <= 1'b0;
      ACCESS_EXCEPTION <= 1'b0;
      case (ext_q)
        dram_hit_pkg::EXT_IDLE: begin
          // chip-select answer is sampled in the same cycle that RESULT.pass_to_cs is high
          if (RESULT.pass_to_cs && !CS_HIT) begin
            EXT_START <= 1'b1;
            ext_q <= dram_hit_pkg::EXT_WAIT;
            ext_cnt_q <= 8'h00;
          end
        end
        dram_hit_pkg::EXT_WAIT: begin
          if (EXT_ACK) begin
            ext_q <= dram_hit_pkg::EXT_IDLE;
          end else if (ext_cnt_q == 8'(EXT_TIMEOUT - 1)) begin
            ACCESS_EXCEPTION <= 1'b1;
            ext_q <= dram_hit_pkg::EXT_IDLE;
          end else begin
            ext_cnt_q <= ext_cnt_q + 8'h01;
          end
        end
        default: begin
          ext_q <= dram_hit_pkg::EXT_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  disabled_no_hit_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !$past(mask_q[0][`FLD_DECODE_ON]) |-> !RESULT.block_hit[0] && !RESULT.wprot_reject)
    else $error("block 0 decoded while disabled");
  reset_clears_on_a: assert property (@(posedge CLOCK)
    $rose(ARST_N) |-> !mask_q[0][`FLD_DECODE_ON] && !mask_q[1][`FLD_DECODE_ON])
    else $error("decode enable set after reset");
  prot_write_block_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    prot_hit[0] |=> !RESULT.block_hit[0] && ADDR_EXCEPTION)
    else $error("protected write reached dram");
  unprot_write_ok_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    raw_hit[0] && !mask_q[0][`FLD_WPROT] |=> RESULT.block_hit[0])
    else $error("unprotected hit lost");
  masked_type_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CYCLE_VALID && CYCLE.user_data && mask_q[0][`FLD_TYPE_LO] |=> !RESULT.block_hit[0])
    else $error("masked access type hit");
  addr_mismatch_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CYCLE_VALID && !mask_q[1][`FLD_CMP_HI] && (CYCLE.addr[`FLD_CMP_HI] != compare_q[1][`FLD_CMP_HI])
    |=> !RESULT.block_hit[1])
    else $error("unmasked mismatch hit");
  masked_bit_hit_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CYCLE_VALID && mask_q[0][`FLD_DECODE_ON] && !CYCLE.write
    && (mask_q[0][`FLD_TYPE_HI:`FLD_TYPE_LO] == 6'h00)
    && (mask_q[0][`FLD_CMP_HI:`FLD_CMP_LO] == 14'h3FFF) |=> RESULT.block_hit[0])
    else $error("fully masked block missed");
  cs_miss_ext_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    RESULT.pass_to_cs && !CS_HIT && ext_q == dram_hit_pkg::EXT_IDLE |=> EXT_START)
    else $error("no external cycle on chip-select miss");
  no_ack_exc_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    EXT_START |-> ##[1:EXC_LAT] (ACCESS_EXCEPTION || EXT_ACK))
    else $error("missing access exception");
  reserved_zero_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (mask_q[1] & ~`MASK_WRITABLE) == 32'h00000000)
    else $error("reserved mask bits stored");

endmodule : dram_block_hit_mask_decode
`default_nettype wire

//--- cycle_master_model.sv
// partner model: internal bus master, chip-select answer, external ack
// assumes the bench calls issue right after a rising edge of CLOCK
`timescale 1ns/1ns
`default_nettype none
module cycle_master_model (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CS_MATCH,
  input wire logic [3:0] ACK_DELAY,
  input wire dram_hit_pkg::hit_result_t RESULT,
  input wire logic EXT_START,
  output logic CYCLE_VALID,
  output dram_hit_pkg::bus_cycle_t CYCLE,
  output logic CS_HIT,
  output logic EXT_ACK
);
  // =========================================
  // cycle issue
  logic [3:0] ack_cnt_q; // cycles left before the ack, zero means none
  initial begin
    CYCLE_VALID = 1'b0;
    CYCLE = '0;
  end
  // one cycle per call; payload inverted afterwards so nothing stale looks valid
  task automatic issue(input dram_hit_pkg::bus_cycle_t c);
    @(posedge CLOCK);
    CYCLE_VALID <= 1'b1;
    CYCLE <= c;
    @(posedge CLOCK);
    CYCLE_VALID <= 1'b0;
    CYCLE <= ~c;
  endtask : issue
  // =========================================
  // chip-select answer, garbage outside the sampling cycle
  assign CS_HIT = RESULT.pass_to_cs ? CS_MATCH : !CS_MATCH;
  // =========================================
  // external fallback ack after a programmable delay, zero never acks
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_cnt_q <= 4'h0;
      EXT_ACK <= 1'b0;
    end else begin
      if (EXT_START) begin
        ack_cnt_q <= ACK_DELAY;
      end else if (ack_cnt_q != 4'h0) begin
        ack_cnt_q <= ack_cnt_q - 4'h1;
      end
      EXT_ACK <= (ack_cnt_q == 4'h1);
    end
  end
endmodule : cycle_master_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the dram block hit decoder
// assumes the map header and the package; axi4-lite master in tasks
`timescale 1ns/1ns
`default_nettype none
`include "dram_hit_map.svh"
module tb_top;
  // =========================================
  // signals
  localparam logic [31:0] CMP0 = 32'hA5540000; // block0 base
  localparam logic [31:0] CMP1 = 32'h12340000; // block1 base
  localparam logic [31:0] MSK0 = 32'h00240001; // bits 21 and 18 masked, on
  logic CLOCK = 1'b0, ARST_N = 1'b0;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, AD = 4'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CYCLE_VALID, CS_HIT, EXT_ACK, CSM = 1'b0;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic EXT_START, ADDR_EXCEPTION, ACCESS_EXCEPTION;
  dram_hit_pkg::bus_cycle_t CYCLE;
  dram_hit_pkg::hit_result_t RESULT;
  int n_mismatch = 0, checks = 0, ticks = 0, n_ext = 0, n_acc = 0, e0, a0;
  // =========================================
  // clock, timeout, event counters
  initial begin
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    ticks++;
    if (EXT_START === 1'b1) n_ext++;
    if (ACCESS_EXCEPTION === 1'b1) n_acc++;
    if (ticks == 5000) begin
      n_mismatch++; // hang cut short
      wrap_up();
    end
  end
  dram_block_hit_mask_decode #(.EXT_TIMEOUT(4)) dram_block_hit_mask_decode_i (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID),
    .S_AXI_AWREADY(AWREADY), .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY), .S_AXI_BRESP(BRESP),
    .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY), .S_AXI_ARADDR(ARADDR),
    .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY), .S_AXI_RDATA(RDATA),
    .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY),
    .CYCLE_VALID(CYCLE_VALID), .CYCLE(CYCLE), .CS_HIT(CS_HIT), .EXT_ACK(EXT_ACK),
    .RESULT(RESULT), .EXT_START(EXT_START), .ADDR_EXCEPTION(ADDR_EXCEPTION),
    .ACCESS_EXCEPTION(ACCESS_EXCEPTION));
  cycle_master_model cycle_master_model_i (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .CS_MATCH(CSM), .ACK_DELAY(AD), .RESULT(RESULT),
    .EXT_START(EXT_START), .CYCLE_VALID(CYCLE_VALID), .CYCLE(CYCLE), .CS_HIT(CS_HIT),
    .EXT_ACK(EXT_ACK));
  // =========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // both channels offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    chk(BRESP, er);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    chk(RDATA, ed);
    chk(RRESP, er);
  endtask : rd
  // result and address exception seen one cycle after the cycle
  task automatic cyc(input logic [31:0] a, input logic w, input logic [5:0] t,
                     input logic [4:0] e);
    cycle_master_model_i.issue({a, w, t});
    #1;
    chk({RESULT, ADDR_EXCEPTION}, e);
  endtask : cyc
  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // =========================================
  // main sequence
  initial begin
    repeat (10) @(posedge CLOCK);
    ARST_N <= 1'b1;
    rd(`OFS_BLK0_MASK, 32'h0, `RESP_OKAY);
    rd(`OFS_BLK1_MASK, 32'h0, `RESP_OKAY);
    wr(`OFS_BLK0_MASK, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFS_BLK0_MASK, 32'hFFFC017F, `RESP_OKAY);
    rd(4'h2, 32'h0, `RESP_SLVERR);
    wr(4'h2, 32'h0, `RESP_SLVERR);
    // base loaded, decode switched off again: no hit
    wr(`OFS_BLK0_COMPARE, CMP0, `RESP_OKAY);
    wr(`OFS_BLK0_MASK, 32'h0, `RESP_OKAY);
    cyc(CMP0, 1'b0, 6'h01, 5'b00000);
    wr(`OFS_BLK0_MASK, MSK0, `RESP_OKAY);
    cyc(CMP0 ^ 32'h00200000, 1'b0, 6'h01, 5'b01000);
    cyc(CMP0 ^ 32'h00400000, 1'b0, 6'h01, 5'b00000);
    cyc(CMP0 | 32'h0003FFFF, 1'b0, 6'h02, 5'b01000);
    wr(`OFS_BLK1_COMPARE, CMP1, `RESP_OKAY);
    wr(`OFS_BLK1_MASK, 32'h1, `RESP_OKAY);
    cyc(CMP1, 1'b1, 6'h01, 5'b10000);
    // each type mask blocks its own type and lets the next type through
    for (int k = 0; k < 6; k++) begin
      wr(`OFS_BLK0_MASK, MSK0 | (32'h1 << (k + 1)), `RESP_OKAY);
      cyc(CMP0, 1'b0, 6'h01 << k, 5'b00000);
      cyc(CMP0, 1'b0, 6'h01 << ((k + 1) % 6), 5'b01000);
    end
    // every compare bit masked: any address hits
    wr(`OFS_BLK0_MASK, 32'hFFFC0001, `RESP_OKAY);
    cyc(~CMP0, 1'b0, 6'h20, 5'b01000);
    // protected block: reads hit, writes refused and handed on
    wr(`OFS_BLK0_MASK, MSK0 | 32'h100, `RESP_OKAY);
    cyc(CMP0, 1'b0, 6'h01, 5'b01000);
    for (int i = 0; i < 4; i++) begin
      CSM <= (i == 0);
      AD <= (i == 3) ? 4'h0 : i[3:0];
      e0 = n_ext;
      a0 = n_acc;
      cyc(CMP0, 1'b1, 6'h01, 5'b00111);
      repeat (12) @(posedge CLOCK);
      chk(n_ext - e0, (i == 0) ? 0 : 1);
      chk(n_acc - a0, (i == 3) ? 1 : 0);
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
